// file: asc_pkg.sv
// Shared constants and types for the converter sequencing control block
`default_nettype none
package asc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] REG_SEQ_CTRL = 4'h2;
   localparam logic [3:0] REG_TIM_CTRL = 4'h3;
   localparam logic [3:0] REG_SCAN_CTRL = 4'h5;
   localparam logic [5:0] ADDR_SEQ_CTRL = 6'h08;
   localparam logic [5:0] ADDR_TIM_CTRL = 6'h0c;
   localparam logic [5:0] ADDR_SCAN_CTRL = 6'h14;
   // Sequence control field positions
   localparam int SEQ_FILL_HALF_BIT = 7;
   localparam int SEQ_SPI_LSB = 2;
   localparam int SEQ_SCAN_BIT = 10;
   localparam int SEQ_SPLIT_BIT = 1;
   localparam int SEQ_SAMPLE_BIT = 0;
   localparam logic [31:0] SEQ_WMASK = 32'h0000_043e;
   // Timing control field positions
   localparam int TIM_SRC_BIT = 15;
   localparam int TIM_EXT_BIT = 14;
   localparam int TIM_SAMC_LSB = 8;
   localparam int TIM_DIV_LSB = 0;
   localparam logic [31:0] TIM_WMASK = 32'h0000_dfff;
   // Auto-scan control field positions
   localparam int SCN_EN_BIT = 15;
   localparam int SCN_LP_BIT = 14;
   localparam int SCN_BG_BIT = 12;
   localparam int SCN_IRQ_LSB = 8;
   localparam int SCN_WM_LSB = 2;
   localparam int SCN_CM_LSB = 0;
   localparam logic [31:0] SCN_WMASK = 32'h0000_d30f;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam int CONV_TADS = 12;
   typedef enum logic [1:0] {ASC_IDLE, ASC_SAMPLE, ASC_CONVERT} asc_state_t;
endpackage
`default_nettype wire

// file: asc_tick_gen.sv
// Converter clock tick divider
`default_nettype none
module asc_tick_gen
   import asc_pkg::*;
#(
   parameter int DIV_W = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Source and divider
   input wire logic src_tick,
   input wire logic [DIV_W-1:0] divider,
   // Converter clock tick
   output logic tad_tick
);
   logic [DIV_W:0] cnt, next_cnt;
   logic next_tad;
   logic [DIV_W:0] limit;

   always_comb begin
      // Zero divider gives one source period, else 2*N
      limit = (divider == '0) ? '0 : ({divider, 1'b0} - 1'b1);
      next_cnt = cnt;
      next_tad = 1'b0;
      if (src_tick) begin
         if (cnt >= limit) begin
            next_cnt = '0;
            next_tad = 1'b1;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt <= '0;
         tad_tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tad_tick <= next_tad;
      end
   end
endmodule
`default_nettype wire

// file: asc_control.sv
// Sequencing, timing and auto-scan control of the sampling converter
`default_nettype none
module asc_control
   import asc_pkg::*;
#(
   parameter int DATA_W = 10,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [5:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Converter side
   input wire logic conv_enable,
   input wire logic rc_tick,
   input wire logic start_auto,
   input wire logic [DATA_W-1:0] conv_result,
   input wire logic [DATA_W-1:0] thresh_lo,
   input wire logic [DATA_W-1:0] thresh_hi,
   // Status and outputs
   output logic sample_hold,
   output logic conv_busy,
   output logic result_we,
   output logic [3:0] result_addr,
   output logic [DATA_W-1:0] result_data,
   output logic conv_irq,
   output logic low_power,
   output logic bandgap_req
);
   logic [31:0] seq_ctrl, tim_ctrl, scan_ctrl;
   logic [31:0] next_seq_ctrl, next_tim_ctrl, next_scan_ctrl;
   asc_state_t state, next_state;
   logic [4:0] manual_sample_cnt, next_manual_sample_cnt;
   logic [3:0] conv_cnt, next_conv_cnt;
   logic [3:0] seq_cnt, next_seq_cnt;
   logic [3:0] wr_ptr, next_wr_ptr;
   logic fill_half, next_fill_half;
   logic manual, next_manual;
   logic ext_hold, next_ext_hold;
   logic next_we, next_irq, next_lp, next_bg;
   logic [DATA_W-1:0] next_data;
   logic [3:0] next_addr;
   logic [31:0] next_rdata;
   logic src_tick, tad_tick, done, match, store, scan_on;
   logic seq_cfg_wr;

   function automatic logic cmp_hit(input logic [1:0] mode, input logic [DATA_W-1:0] v,
                                    input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
      logic r;
      r = 1'b0;
      case (mode)
         2'h0: r = v < lo;
         2'h1: r = v > lo;
         2'h2: r = (v >= lo) && (v <= hi);
         default: r = (v < lo) || (v > hi);
      endcase
      return r;
   endfunction

   // (bus clock runs 1:1, so every cycle is a source tick)
   assign src_tick = tim_ctrl[TIM_SRC_BIT] ? rc_tick : 1'b1;

   asc_tick_gen #(.DIV_W(8)) u_tick (
      .clk_sys(clk_sys),
      .rst(rst),
      .src_tick(src_tick),
      .divider(tim_ctrl[TIM_DIV_LSB +: 8]),
      .tad_tick(tad_tick)
   );

   assign scan_on = scan_ctrl[SCN_EN_BIT];
   // Only a changed setting restarts counting; sample-bit writes share the register
   assign seq_cfg_wr = reg_wr && (reg_addr == ADDR_SEQ_CTRL) &&
                       (((reg_wdata ^ seq_ctrl) & SEQ_WMASK) != '0);
   assign done = (state == ASC_CONVERT) && tad_tick && (conv_cnt == 4'(CONV_TADS - 1));
   assign match = cmp_hit(scan_ctrl[SCN_CM_LSB +: 2], conv_result, thresh_lo, thresh_hi);

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_comb begin
      next_seq_ctrl = seq_ctrl;
      next_tim_ctrl = tim_ctrl;
      next_scan_ctrl = scan_ctrl;
      next_manual = manual;
      if (reg_wr && reg_addr == ADDR_SEQ_CTRL) begin
         next_seq_ctrl = reg_wdata & SEQ_WMASK;
      end else if (reg_wr && reg_addr == ADDR_TIM_CTRL) begin
         next_tim_ctrl = reg_wdata & TIM_WMASK;
      end else if (reg_wr && reg_addr == ADDR_SCAN_CTRL) begin
         next_scan_ctrl = reg_wdata & SCN_WMASK;
      end
      if (reg_wr && reg_addr == ADDR_SEQ_CTRL) begin
         next_manual = reg_wdata[SEQ_SAMPLE_BIT] && conv_enable;
      end else if (!conv_enable || scan_on) begin
         next_manual = 1'b0;
      end
      next_rdata = '0;
      if (reg_rd && reg_addr == ADDR_SEQ_CTRL) begin
         next_rdata = seq_ctrl;
         next_rdata[SEQ_FILL_HALF_BIT] = fill_half && seq_ctrl[SEQ_SPLIT_BIT];
         next_rdata[SEQ_SAMPLE_BIT] = sample_hold;
      end else if (reg_rd && reg_addr == ADDR_TIM_CTRL) begin
         next_rdata = tim_ctrl;
      end else if (reg_rd && reg_addr == ADDR_SCAN_CTRL) begin
         next_rdata = scan_ctrl;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         seq_ctrl <= REG_RESET;
         tim_ctrl <= REG_RESET;
         scan_ctrl <= REG_RESET;
         manual <= 1'b0;
         reg_rdata <= '0;
      end else begin
         seq_ctrl <= next_seq_ctrl;
         tim_ctrl <= next_tim_ctrl;
         scan_ctrl <= next_scan_ctrl;
         manual <= next_manual;
         reg_rdata <= next_rdata;
      end
   end

   // -------------------------------------------------------------
   // Sample and convert sequencer
   // -------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_manual_sample_cnt = manual_sample_cnt;
      next_conv_cnt = conv_cnt;
      next_ext_hold = ext_hold;
      case (state)
         ASC_IDLE: begin
            next_manual_sample_cnt = '0;
            if (conv_enable && (manual || (scan_on && start_auto))) begin
               next_state = ASC_SAMPLE;
               next_ext_hold = tim_ctrl[TIM_EXT_BIT];
            end
         end
         ASC_SAMPLE: begin
            if (!conv_enable) begin
               next_state = ASC_IDLE;
            end else if (scan_on) begin
               // Auto-sample counted in converter clocks
               if (tad_tick) begin
                  next_manual_sample_cnt = manual_sample_cnt + 5'h01;
                  if (manual_sample_cnt + 5'h01 >= tim_ctrl[TIM_SAMC_LSB +: 5]) begin
                     next_state = ASC_CONVERT;
                     next_conv_cnt = '0;
                  end
               end
            end else if (!manual) begin
               // Extended sampling runs out the auto-sample time first
               if (!ext_hold || (tad_tick &&
                   manual_sample_cnt + 5'h01 >= tim_ctrl[TIM_SAMC_LSB +: 5])) begin
                  next_state = ASC_CONVERT;
                  next_conv_cnt = '0;
               end else if (tad_tick) begin
                  next_manual_sample_cnt = manual_sample_cnt + 5'h01;
               end
            end
         end
         ASC_CONVERT: begin
            if (!conv_enable) begin
               next_state = ASC_IDLE;
            end else if (tad_tick) begin
               next_conv_cnt = conv_cnt + 4'h1;
               if (done) begin
                  next_state = ASC_IDLE;
               end
            end
         end
         default: next_state = ASC_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= ASC_IDLE;
         manual_sample_cnt <= '0;
         conv_cnt <= '0;
         ext_hold <= 1'b0;
         sample_hold <= 1'b0;
         conv_busy <= 1'b0;
      end else begin
         state <= next_state;
         manual_sample_cnt <= next_manual_sample_cnt;
         conv_cnt <= next_conv_cnt;
         ext_hold <= next_ext_hold;
         sample_hold <= (next_state == ASC_SAMPLE);
         conv_busy <= (next_state == ASC_CONVERT);
      end
   end

   // -------------------------------------------------------------
   // Result store, sequence count and interrupt
   // -------------------------------------------------------------
   always_comb begin
      store = 1'b0;
      case (scan_on ? scan_ctrl[SCN_WM_LSB +: 2] : 2'h0)
         2'h0: store = 1'b1;
         2'h1: store = match;
         default: store = 1'b0;
      endcase
      next_we = done && store;
      next_addr = wr_ptr;
      next_data = conv_result;
      next_wr_ptr = wr_ptr;
      next_fill_half = fill_half;
      next_seq_cnt = seq_cnt;
      next_irq = 1'b0;
      if (next_we) begin
         if (seq_ctrl[SEQ_SPLIT_BIT]) begin
            next_addr = {fill_half, wr_ptr[2:0]};
            next_wr_ptr = {1'b0, wr_ptr[2:0] + 3'h1};
            if (wr_ptr[2:0] == 3'h7) begin
               next_fill_half = !fill_half;
            end
         end else begin
            next_wr_ptr = wr_ptr + 4'(DEPTH / 16);
         end
      end
      if (done) begin
         if (scan_on) begin
            case (scan_ctrl[SCN_IRQ_LSB +: 2])
               2'h1: next_irq = 1'b1;
               2'h2: next_irq = match && scan_ctrl[SCN_WM_LSB +: 2] != 2'h0;
               2'h3: next_irq = match && scan_ctrl[SCN_WM_LSB +: 2] != 2'h0;
               default: next_irq = 1'b0;
            endcase
         end else begin
            if (seq_cnt >= seq_ctrl[SEQ_SPI_LSB +: 4]) begin
               next_seq_cnt = '0;
               next_irq = 1'b1;
            end else begin
               next_seq_cnt = seq_cnt + 4'h1;
            end
         end
      end
      if (seq_cfg_wr) begin
         next_seq_cnt = '0;
         next_wr_ptr = '0;
         next_fill_half = 1'b0;
      end
      next_lp = scan_on && scan_ctrl[SCN_LP_BIT] && next_state == ASC_IDLE;
      next_bg = scan_ctrl[SCN_BG_BIT] && conv_enable && next_state != ASC_IDLE;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         fill_half <= 1'b0;
         seq_cnt <= '0;
         result_we <= 1'b0;
         result_addr <= '0;
         result_data <= '0;
         conv_irq <= 1'b0;
         low_power <= 1'b0;
         bandgap_req <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         fill_half <= next_fill_half;
         seq_cnt <= next_seq_cnt;
         result_we <= next_we;
         result_addr <= next_addr;
         result_data <= next_data;
         conv_irq <= next_irq;
         low_power <= next_lp;
         bandgap_req <= next_bg;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   irq_after_done_a: assert property (@(posedge clk_sys) disable iff (rst)
      conv_irq |-> $past(done)) else $error("interrupt without a finished sequence");
   irq_off_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
      $past(scan_on && scan_ctrl[SCN_IRQ_LSB +: 2] == 2'h0) |-> !conv_irq)
      else $error("irq in mode 00");
   discard_a: assert property (@(posedge clk_sys) disable iff (rst)
      $past(scan_on && scan_ctrl[SCN_WM_LSB +: 2] == 2'h2) |-> !result_we)
      else $error("stored in mode 10");
   legacy_store_a: assert property (@(posedge clk_sys) disable iff (rst)
      ($past(done) && !$past(scan_on)) |-> result_we) else $error("legacy result lost");
   upper_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
      reg_rdata[31:16] == 16'h0000) else $error("upper bits not zero");
   sample_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == ADDR_SEQ_CTRL) |=> reg_rdata[SEQ_SAMPLE_BIT] == $past(sample_hold))
      else $error("sample bit does not follow sampling");
   bandgap_a: assert property (@(posedge clk_sys) disable iff (rst)
      bandgap_req |-> $past(scan_ctrl[SCN_BG_BIT])) else $error("band gap without request");
   split_half_a: assert property (@(posedge clk_sys) disable iff (rst)
      (result_we && seq_ctrl[SEQ_SPLIT_BIT]) |-> result_addr[3] == $past(fill_half))
      else $error("wrong half written");
endmodule
`default_nettype wire

// file: test_adc_sequencing_control.sv
// Self-checking bench for the converter sequencing control block
`default_nettype none
module test_adc_sequencing_control
   import asc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [5:0] reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic conv_enable = 1'b0;
   logic rc_tick = 1'b0;
   logic rc_run = 1'b0;
   logic start_auto = 1'b0;
   logic [9:0] conv_result = 10'h000;
   logic [9:0] thresh_lo = 10'h064;
   logic [9:0] thresh_hi = 10'h12c;
   logic [31:0] reg_rdata;
   logic sample_hold, conv_busy, result_we, conv_irq, low_power, bandgap_req;
   logic [3:0] result_addr, w_addr;
   logic [9:0] result_data, w_data;
   logic w_we, w_irq, w_bg;
   int w_n, w_sh, n0;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   // Rows: scan config, result, expected {store, irq}
   logic [31:0] cfg [8] = '{32'hc100, 32'h9000, 32'h8205, 32'hd205,
                            32'h8208, 32'h830a, 32'h830b, 32'h8107};
   logic [9:0] res [8] = '{10'h032, 10'h032, 10'h032, 10'h0c8,
                           10'h032, 10'h096, 10'h096, 10'h190};
   logic [1:0] ex [8] = '{2'h3, 2'h2, 2'h0, 2'h3, 2'h1, 2'h1, 2'h0, 2'h3};

   asc_control dut (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .conv_enable(conv_enable), .rc_tick(rc_tick), .start_auto(start_auto),
      .conv_result(conv_result), .thresh_lo(thresh_lo), .thresh_hi(thresh_hi),
      .sample_hold(sample_hold), .conv_busy(conv_busy), .result_we(result_we),
      .result_addr(result_addr), .result_data(result_data), .conv_irq(conv_irq),
      .low_power(low_power), .bandgap_req(bandgap_req)
   );

   always #25 clk_sys = ~clk_sys;
   // Slow source: one pulse every other cycle, only when enabled
   always @(posedge clk_sys) begin
      rc_tick <= rc_run & ~rc_tick;
   end
   // Whole run needs about a thousand cycles; anything far beyond is a hang
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic give_verdict();
      if (errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Gap cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      cmp(reg_rdata, exp);
      @(posedge clk_sys);
   endtask
   task automatic watch(input int lim);
      int k;
      logic busy_seen;
      k = 0;
      busy_seen = 1'b0;
      w_n = 0;
      w_we = 1'b0;
      w_irq = 1'b0;
      w_bg = 1'b0;
      w_sh = 0;
      while (k < lim) begin
         @(negedge clk_sys);
         k++;
         if (result_we === 1'b1 && !w_we) begin
            w_n = k;
            w_we = 1'b1;
            w_addr = result_addr;
            w_data = result_data;
         end
         if (conv_irq === 1'b1) w_irq = 1'b1;
         if (sample_hold === 1'b1) w_sh++;
         if (conv_busy === 1'b1) begin
            busy_seen = 1'b1;
            if (bandgap_req === 1'b1) w_bg = 1'b1;
         end
         if (busy_seen && conv_busy === 1'b0 && lim > k + 4) lim = k + 4;
      end
      @(posedge clk_sys);
   endtask
   task automatic manual(input logic [31:0] seq, input int lim);
      wr(ADDR_SEQ_CTRL, seq | 32'h1);
      wr(ADDR_SEQ_CTRL, seq);
      watch(lim);
   endtask
   task automatic scan_once();
      start_auto <= 1'b1;
      @(posedge clk_sys);
      start_auto <= 1'b0;
      watch(300);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(ADDR_SEQ_CTRL, REG_RESET);
      rd(ADDR_TIM_CTRL, REG_RESET);
      rd(ADDR_SCAN_CTRL, REG_RESET);
      wr(6'h10, 32'hffff_ffff);
      rd(6'h10, 32'h0);
      wr(ADDR_SEQ_CTRL, 32'hffff_fc7e);
      rd(ADDR_SEQ_CTRL, 32'h0000_043e);
      wr(ADDR_TIM_CTRL, 32'hffff_ffff);
      rd(ADDR_TIM_CTRL, 32'h0000_dfff);
      wr(ADDR_SCAN_CTRL, 32'hffff_7ff7);
      rd(ADDR_SCAN_CTRL, 32'h0000_5307);
      wr(ADDR_SCAN_CTRL, 32'h0);
   endtask
   task automatic t_manual();
      conv_result <= 10'h2a5;
      wr(ADDR_TIM_CTRL, 32'h0100);
      wr(ADDR_SEQ_CTRL, 32'h1);
      rd(ADDR_SEQ_CTRL, 32'h1);
      cmp(sample_hold, 1'b1);
      wr(ADDR_SEQ_CTRL, 32'h0);
      @(negedge clk_sys);
      cmp(sample_hold, 1'b0);
      watch(300);
      cmp({w_we, w_irq}, 2'h3);
      cmp(w_data, 10'h2a5);
      manual(32'h0, 300);
      n0 = w_n;
      wr(ADDR_TIM_CTRL, 32'h0102);
      manual(32'h0, 400);
      cmp(w_n - n0, CONV_TADS * 3);
      // Three sequences per interrupt, then a changed setting restarts the count
      for (int i = 0; i < 5; i++) begin
         manual(i < 4 ? 32'h8 : 32'h4, 300);
         cmp(w_irq, i == 2);
      end
   endtask
   task automatic t_ext_src();
      wr(ADDR_TIM_CTRL, 32'h4400);
      wr(ADDR_SEQ_CTRL, 32'h1);
      wr(ADDR_SEQ_CTRL, 32'h0);
      cmp(sample_hold, 1'b1);
      watch(300);
      cmp(w_we, 1'b1);
      wr(ADDR_TIM_CTRL, 32'h8100);
      manual(32'h0, 60);
      cmp(w_we, 1'b0);
      rc_run <= 1'b1;
      watch(300);
      cmp(w_we, 1'b1);
      rc_run <= 1'b0;
   endtask
   task automatic t_scan();
      // Sequence count set high; auto-scan must ignore it
      wr(ADDR_SEQ_CTRL, 32'h0000_040c);
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_TIM_CTRL, (i == 7 ? 32'd31 : i + 1) << TIM_SAMC_LSB);
         conv_result <= res[i];
         wr(ADDR_SCAN_CTRL, cfg[i]);
         scan_once();
         cmp(w_sh, i == 7 ? 31 : i + 1);
         cmp({w_we, w_irq}, ex[i]);
         cmp(low_power, cfg[i][SCN_LP_BIT]);
         cmp(w_bg, cfg[i][SCN_BG_BIT]);
      end
   endtask
   task automatic t_split();
      wr(ADDR_TIM_CTRL, 32'h0100);
      wr(ADDR_SEQ_CTRL, 32'h2);
      wr(ADDR_SCAN_CTRL, 32'h8100);
      for (int i = 0; i < 9; i++) begin
         scan_once();
         cmp(w_addr, i);
         if (i == 7) rd(ADDR_SEQ_CTRL, 32'h82);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      conv_enable <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_manual();
      t_ext_src();
      t_scan();
      t_split();
      give_verdict();
   end
endmodule
`default_nettype wire
